/* File: adcb_consts.svh */
// constants of the converter configuration bank and its serial controller
`ifndef ADCB_CONSTS_SVH
`define ADCB_CONSTS_SVH

`define ADCB_ADDR_KEY       11'h000
`define ADCB_ADDR_PD        11'h004
`define ADCB_ADDR_SDI       11'h008
`define ADCB_ADDR_OUTPROT   11'h00c
`define ADCB_ADDR_OUTRATE   11'h00d
`define ADCB_ADDR_OUTRSVD   11'h00e
`define ADCB_ADDR_STATPIN   11'h00f
`define ADCB_ADDR_WORD      11'h010
`define ADCB_ADDR_PARITY    11'h011

`define ADCB_MASK_KEY       8'hff
`define ADCB_MASK_PD        8'h1e
`define ADCB_MASK_SDI       8'h03
`define ADCB_MASK_OUTPROT   8'h77
`define ADCB_MASK_OUTRATE   8'h01
`define ADCB_MASK_OUTRSVD   8'h00
`define ADCB_MASK_STATPIN   8'hff
`define ADCB_MASK_WORD      8'hff
`define ADCB_MASK_PARITY    8'hff

`define ADCB_RESET_VALUE    8'h00
`define ADCB_UNLOCK_KEY     8'haa

`define ADCB_PD_HALF_REF    4
`define ADCB_REFERENCE_OFF         3
`define ADCB_REFERENCE_OFF_BUF     2
`define ADCB_PD_CONVERTER   1

`define ADCB_FRAME_BITS     24
`define ADCB_CMD_HI         23
`define ADCB_CMD_LO         19
`define ADCB_ADDR_HI        18
`define ADCB_ADDR_LO        8

`define ADCB_HOST_FRAME     12'h000
`define ADCB_HOST_STATUS    12'h004
`define ADCB_HOST_RXDATA    12'h008
`define ADCB_HOST_MODE      12'h00c

`define ADCB_HALF_PERIOD    4

`endif

/* File: adcb_device.sv */
// configuration register bank of the converter, serial slave end
//
// Summary of operation
// - key 8'haa in key register unlocks writes
// - any other key value keeps writes locked
// - key cleared at reset, so bank starts locked
// - key, power-down, protocol registers reset zero
// - bit 4 powers down half-reference buffer
// - bit 3 powers down internal reference
// - bit 2 powers down reference buffer
// - bit 1 powers down converter module
// - converter power-down applied at chip-select rising
// - converter power-up starts at chip-select rising
// - reference buffer off at chip-select rising
// - reference off at chip-select rising
// - protocol field selects clock polarity and phase
// - reserved bits always read as zero
// - 24-bit write frame committed at chip-select rising
// - read data leads the next frame's output
// - set and clear touch only masked bits
`timescale 1ns/100ps
`default_nettype none
`include "adcb_consts.svh"

module adcb_device (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// serial link
	adcb_spi_if.dev          spi,
	// power-down controls
	output logic             half_ref_buffer_off,
	output logic             reference_off,
	output logic             ref_buffer_off,
	output logic             converter_off,
	// protocol and output configuration
	output logic [1:0]       write_protocol_field,
	output logic [7:0]       output_protocol_ctrl,
	output logic [7:0]       output_rate_ctrl,
	output logic [7:0]       status_pin_cfg,
	output logic [7:0]       output_word_cfg,
	output logic [7:0]       parity_cfg
);

	localparam int NREG = 9;

	localparam logic [10:0] reg_addr [NREG] = '{
		`ADCB_ADDR_KEY, `ADCB_ADDR_PD, `ADCB_ADDR_SDI,
		`ADCB_ADDR_OUTPROT, `ADCB_ADDR_OUTRATE, `ADCB_ADDR_OUTRSVD,
		`ADCB_ADDR_STATPIN, `ADCB_ADDR_WORD, `ADCB_ADDR_PARITY
	};

	localparam logic [7:0] reg_mask [NREG] = '{
		`ADCB_MASK_KEY, `ADCB_MASK_PD, `ADCB_MASK_SDI,
		`ADCB_MASK_OUTPROT, `ADCB_MASK_OUTRATE, `ADCB_MASK_OUTRSVD,
		`ADCB_MASK_STATPIN, `ADCB_MASK_WORD, `ADCB_MASK_PARITY
	};

	logic [7:0]                 regs [NREG];
	logic                       sclk_q;
	logic                       cs_n_q;
	logic [23:0]                rx_shift;
	logic [4:0]                 bit_count;
	logic [23:0]                tx_shift;
	logic                       first_launch;
	logic [7:0]                 read_pending;
	logic                       sclk_rise;
	logic                       sclk_fall;
	logic                       cs_fall;
	logic                       cs_rise;
	logic                       in_frame;
	logic                       sample_edge;
	logic                       launch_edge;
	logic                       commit;
	logic                       unlocked;
	logic [7:0]                 read_value;
	adcb_pkg::adcb_cmd_type     frame_cmd;
	logic [10:0]                frame_addr;
	logic [7:0]                 frame_data;

	////////////////////////////////////////////////////////////////////////////////
	// edge detection on the link, all inputs taken as synchronous to pclk

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sclk_q <= 1'b0;
			cs_n_q <= 1'b1;
		end else begin
			sclk_q <= spi.sclk;
			cs_n_q <= spi.cs_n;
		end
	end

	assign sclk_rise = spi.sclk & ~sclk_q;
	assign sclk_fall = ~spi.sclk & sclk_q;
	assign cs_fall   = ~spi.cs_n & cs_n_q;
	assign cs_rise   = spi.cs_n & ~cs_n_q;
	assign in_frame  = ~spi.cs_n & ~cs_n_q;

	// the field only changes at frame end, so a frame runs wholly under one mode
	// modes 00 and 11 sample on rising sclk, 01 and 10 on falling
	assign sample_edge = (write_protocol_field[1] == write_protocol_field[0]) ?
		sclk_rise : sclk_fall;
	assign launch_edge = (write_protocol_field[1] == write_protocol_field[0]) ?
		sclk_fall : sclk_rise;

	////////////////////////////////////////////////////////////////////////////////
	// frame capture

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_shift  <= 24'h000000;
			bit_count <= 5'h00;
		end else if (cs_fall) begin
			bit_count <= 5'h00;
		end else if (in_frame && sample_edge) begin
			rx_shift <= {rx_shift[22:0], spi.sdi};
			if (bit_count != 5'h1f) begin
				bit_count <= bit_count + 5'h01;
			end
		end
	end

	assign frame_cmd  = adcb_pkg::adcb_cmd_type'(rx_shift[`ADCB_CMD_HI:`ADCB_CMD_LO]);
	assign frame_addr = rx_shift[`ADCB_ADDR_HI:`ADCB_ADDR_LO];
	assign frame_data = rx_shift[7:0];
	// frames of any other length are dropped whole
	assign commit     = cs_rise && (bit_count == 5'(`ADCB_FRAME_BITS));
	assign unlocked   = (regs[0] == `ADCB_UNLOCK_KEY);

	////////////////////////////////////////////////////////////////////////////////
	// register entries

	genvar gi;
	generate
		for (gi = 0; gi < NREG; gi++) begin : g_reg
			logic       hit;
			logic [7:0] next_value;

			// entry 0 is the key itself and is never locked
			assign hit = commit && (frame_addr == reg_addr[gi]) &&
				((gi == 0) || unlocked);

			always_comb begin
				next_value = regs[gi];
				case (frame_cmd)
					adcb_pkg::adcb_cmd_write: next_value = frame_data;
					adcb_pkg::adcb_cmd_set:   next_value = regs[gi] | frame_data;
					adcb_pkg::adcb_cmd_clear: next_value = regs[gi] & ~frame_data;
					default:                  next_value = regs[gi];
				endcase
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					regs[gi] <= `ADCB_RESET_VALUE;
				end else if (hit) begin
					regs[gi] <= next_value & reg_mask[gi];
				end
			end
		end
	endgenerate

	always_comb begin
		read_value = 8'h00;
		for (int i = 0; i < NREG; i++) begin
			if (frame_addr == reg_addr[i]) begin
				read_value = regs[i];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read return

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			read_pending <= 8'h00;
		end else if (commit) begin
			read_pending <= (frame_cmd == adcb_pkg::adcb_cmd_read) ? read_value : 8'h00;
		end
	end

	// both phases show the first bit at chip-select fall, phase 1 holds it over the first launch edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_shift     <= 24'h000000;
			first_launch <= 1'b0;
		end else if (cs_fall) begin
			tx_shift     <= {read_pending, 16'h0000};
			first_launch <= 1'b1;
		end else if (in_frame && launch_edge) begin
			first_launch <= 1'b0;
			if (!(write_protocol_field[0] && first_launch)) begin
				tx_shift <= {tx_shift[22:0], 1'b0};
			end
		end
	end

	assign spi.sdo = tx_shift[23];

	////////////////////////////////////////////////////////////////////////////////
	// outputs, each follows its register so it moves at chip-select rising

	assign half_ref_buffer_off  = regs[1][`ADCB_PD_HALF_REF];
	assign reference_off        = regs[1][`ADCB_REFERENCE_OFF];
	assign ref_buffer_off       = regs[1][`ADCB_REFERENCE_OFF_BUF];
	// host must allow the wake time after this falls before converting
	assign converter_off        = regs[1][`ADCB_PD_CONVERTER];
	assign write_protocol_field = regs[2][1:0];
	assign output_protocol_ctrl = regs[3];
	assign output_rate_ctrl     = regs[4];
	assign status_pin_cfg       = regs[6];
	assign output_word_cfg      = regs[7];
	assign parity_cfg           = regs[8];

endmodule

`default_nettype wire

/* File: adcb_host.sv */
// serial host controller for the configuration bank, software side over APB
`timescale 1ns/100ps
`default_nettype none
`include "adcb_consts.svh"

module adcb_host #(
	parameter int HALF = `ADCB_HALF_PERIOD
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// serial link
	adcb_spi_if.host         spi
);

	adcb_pkg::adcb_state_type state;
	logic [1:0]               mode;
	logic [23:0]              tx_shift;
	logic [23:0]              rx_word;
	logic [7:0]               timer;
	logic [5:0]               edges;
	logic                     sclk_r;
	logic                     cs_n_r;
	logic                     busy;
	logic                     setup;
	logic                     access;
	logic                     start;
	logic                     mapped;
	logic                     refuse;
	logic                     tick;
	logic                     leading;

	////////////////////////////////////////////////////////////////////////////////
	// apb slave, zero wait states, read data captured in the setup cycle

	assign busy    = (state != adcb_pkg::adcb_st_idle);
	assign setup   = psel & ~penable;
	assign access  = psel & penable;
	assign mapped  = (paddr == `ADCB_HOST_FRAME) || (paddr == `ADCB_HOST_STATUS) ||
		(paddr == `ADCB_HOST_RXDATA) || (paddr == `ADCB_HOST_MODE);
	// a frame request while one is running is refused rather than queued
	assign refuse  = ~mapped || (pwrite && (paddr == `ADCB_HOST_FRAME) && busy);
	assign start   = access && pwrite && (paddr == `ADCB_HOST_FRAME) && !busy;
	assign pready  = 1'b1;
	assign pslverr = access & refuse;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (setup && !pwrite) begin
			case (paddr)
				`ADCB_HOST_STATUS: prdata <= {31'h00000000, busy};
				`ADCB_HOST_RXDATA: prdata <= {8'h00, rx_word};
				`ADCB_HOST_MODE:   prdata <= {30'h00000000, mode};
				default:           prdata <= 32'h00000000;
			endcase
		end
	end

	// software sets this after the device has taken the same protocol
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode <= 2'b00;
		end else if (access && pwrite && (paddr == `ADCB_HOST_MODE) && !busy) begin
			mode <= pwdata[1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// frame sequencer

	assign tick    = (timer == 8'h00);
	assign leading = ~edges[0];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state    <= adcb_pkg::adcb_st_idle;
			timer    <= 8'h00;
			edges    <= 6'h00;
			sclk_r   <= 1'b0;
			cs_n_r   <= 1'b1;
			tx_shift <= 24'h000000;
			rx_word  <= 24'h000000;
		end else begin
			timer <= tick ? 8'(HALF - 1) : timer - 8'h01;
			case (state)
				adcb_pkg::adcb_st_idle: begin
					sclk_r <= mode[1];
					if (start) begin
						tx_shift <= pwdata[23:0];
						cs_n_r   <= 1'b0;
						timer    <= 8'(HALF - 1);
						state    <= adcb_pkg::adcb_st_lead;
					end
				end
				adcb_pkg::adcb_st_lead: begin
					if (tick) begin
						edges <= 6'h00;
						state <= adcb_pkg::adcb_st_clock;
					end
				end
				adcb_pkg::adcb_st_clock: begin
					if (tick) begin
						sclk_r <= ~sclk_r;
						edges  <= edges + 6'h01;
						// phase 1 launches on leading edges, phase 0 on trailing
						if (leading == mode[0]) begin
							if (!(mode[0] && edges == 6'h00)) begin
								tx_shift <= {tx_shift[22:0], 1'b0};
							end
						end else begin
							rx_word <= {rx_word[22:0], spi.sdo};
						end
						if (edges == 6'(2 * `ADCB_FRAME_BITS - 1)) begin
							state <= adcb_pkg::adcb_st_tail;
						end
					end
				end
				adcb_pkg::adcb_st_tail: begin
					if (tick) begin
						cs_n_r <= 1'b1;
						state  <= adcb_pkg::adcb_st_gap;
					end
				end
				adcb_pkg::adcb_st_gap: begin
					if (tick) begin
						state <= adcb_pkg::adcb_st_idle;
					end
				end
				default: begin
					state <= adcb_pkg::adcb_st_idle;
				end
			endcase
		end
	end

	assign spi.cs_n = cs_n_r;
	assign spi.sclk = sclk_r;
	assign spi.sdi  = tx_shift[23];

endmodule

`default_nettype wire

/* File: adcb_link_props.sv */
// assertions on the serial link and the bank outputs
`timescale 1ns/100ps
`default_nettype none

module adcb_link_props (
	// clock and reset
	input wire logic       pclk,
	input wire logic       presetn,
	// serial link
	input wire logic       cs_n,
	input wire logic       sclk,
	// bank outputs
	input wire logic       half_ref_buffer_off,
	input wire logic       reference_off,
	input wire logic       ref_buffer_off,
	input wire logic       converter_off,
	input wire logic [1:0] write_protocol_field
);
	logic       cs_q;
	logic       sclk_q;
	logic [6:0] tog;
	wire        commit = cs_n & ~cs_q;

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cs_q   <= 1'b1;
			sclk_q <= 1'b0;
		end else begin
			cs_q   <= cs_n;
			sclk_q <= sclk;
		end
	end

	// edges counted only inside a frame
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tog <= 7'h00;
		else if (cs_n)
			tog <= 7'h00;
		else if (sclk != sclk_q)
			tog <= tog + 7'h01;
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_conv; $changed(converter_off) |-> $past(commit); endproperty
	a_conv: assert property (p_conv)
		else $error("converter power-down moved outside a frame end");
	property p_refbuf; $changed(ref_buffer_off) |-> $past(commit); endproperty
	a_refbuf: assert property (p_refbuf)
		else $error("reference buffer control moved outside a frame end");
	property p_ref; $changed(reference_off) |-> $past(commit); endproperty
	a_ref: assert property (p_ref)
		else $error("reference control moved outside a frame end");
	property p_half; $changed(half_ref_buffer_off) |-> $past(commit); endproperty
	a_half: assert property (p_half)
		else $error("half reference control moved outside a frame end");
	property p_mode; $changed(write_protocol_field) |-> $past(commit); endproperty
	a_mode: assert property (p_mode)
		else $error("protocol field moved inside a frame");
	property p_len; $rose(cs_n) |-> tog == 7'h30; endproperty
	a_len: assert property (p_len)
		else $error("frame did not carry 24 clock periods");
	property p_lead; $fell(cs_n) |-> $stable(sclk) [*3]; endproperty
	a_lead: assert property (p_lead)
		else $error("serial clock moved right after select");
	property p_bound; $fell(cs_n) |-> ##[1:1000] cs_n; endproperty
	a_bound: assert property (p_bound)
		else $error("frame did not end in time");

	c_conv: cover property ($rose(converter_off));
	c_mode: cover property (write_protocol_field == 2'h3);
	c_len:  cover property ($rose(cs_n) && tog == 7'h30);
endmodule

`default_nettype wire

/* File: adcb_pkg.sv */
// types shared by both ends of the configuration link
`default_nettype none

package adcb_pkg;

	typedef enum logic [4:0] {
		adcb_cmd_nop   = 5'h00,
		adcb_cmd_write = 5'h01,
		adcb_cmd_read  = 5'h02,
		adcb_cmd_set   = 5'h03,
		adcb_cmd_clear = 5'h04
	} adcb_cmd_type;

	typedef enum logic [2:0] {
		adcb_st_idle  = 3'b000,
		adcb_st_lead  = 3'b001,
		adcb_st_clock = 3'b010,
		adcb_st_tail  = 3'b011,
		adcb_st_gap   = 3'b100
	} adcb_state_type;

endpackage

`default_nettype wire

/* File: adcb_spi_if.sv */
// serial link between the host controller and the configuration bank
`timescale 1ns/100ps
`default_nettype none

interface adcb_spi_if;
	logic cs_n;
	logic sclk;
	logic sdi;
	logic sdo;

	modport dev (
		input  cs_n,
		input  sclk,
		input  sdi,
		output sdo
	);

	modport host (
		output cs_n,
		output sclk,
		output sdi,
		input  sdo
	);
endinterface

`default_nettype wire

/* File: testbench.sv */
// self-checking bench: host controller driving the configuration bank
`timescale 1ns/100ps
`default_nettype none
`include "adcb_consts.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
	$display("[ERR] %s expected %h seen %h", nm, e, g); end end

module testbench;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic        slv;
	logic        half_ref_buffer_off, reference_off, ref_buffer_off, converter_off;
	logic [1:0]  write_protocol_field;
	logic [7:0]  output_protocol_ctrl, output_rate_ctrl, status_pin_cfg;
	logic [7:0]  output_word_cfg, parity_cfg;
	logic [3:0]  pd_out;
	int          err_total, n_tests;

	assign pd_out = {half_ref_buffer_off, reference_off, ref_buffer_off, converter_off};

	////////////////////////////////////////////////////////////////////////////////
	adcb_spi_if spi_bus ();
	adcb_host u_adcb_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .spi(spi_bus.host));
	adcb_device u_adcb_device (.pclk(pclk), .presetn(presetn), .spi(spi_bus.dev),
		.half_ref_buffer_off(half_ref_buffer_off), .reference_off(reference_off),
		.ref_buffer_off(ref_buffer_off), .converter_off(converter_off),
		.write_protocol_field(write_protocol_field),
		.output_protocol_ctrl(output_protocol_ctrl), .output_rate_ctrl(output_rate_ctrl),
		.status_pin_cfg(status_pin_cfg), .output_word_cfg(output_word_cfg),
		.parity_cfg(parity_cfg));
	adcb_link_props u_props (.pclk(pclk), .presetn(presetn), .cs_n(spi_bus.cs_n),
		.sclk(spi_bus.sclk), .half_ref_buffer_off(half_ref_buffer_off),
		.reference_off(reference_off), .ref_buffer_off(ref_buffer_off),
		.converter_off(converter_off), .write_protocol_field(write_protocol_field));

	////////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// request held until pready is seen with the access phase
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		slv = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// busy is polled after the request, so a frame that follows this task is not refused for overlap
	task automatic frame(input logic [4:0] c, input logic [10:0] a, input logic [7:0] d);
		apb(1'b1, `ADCB_HOST_FRAME, {8'h00, c, a, d});
		r = 32'h1;
		while (r[0] !== 1'b0) apb(1'b0, `ADCB_HOST_STATUS, 32'h0);
	endtask

	task automatic wr(input logic [10:0] a, input logic [7:0] d);
		frame(adcb_pkg::adcb_cmd_write, a, d);
	endtask

	task automatic rd(input logic [10:0] a, input logic [7:0] e, input string nm);
		frame(adcb_pkg::adcb_cmd_read, a, 8'h00);
		frame(adcb_pkg::adcb_cmd_nop, 11'h000, 8'h00);
		apb(1'b0, `ADCB_HOST_RXDATA, 32'h0);
		`CHK(nm, e, r[23:16])
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	initial begin
		repeat (60000) @(posedge pclk);
		err_total++;
		give_verdict();
	end

	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		`CHK("pd reset", 4'h0, pd_out)
		`CHK("mode reset", 2'h0, write_protocol_field)
		rd(`ADCB_ADDR_KEY, 8'h00, "key reset");
		wr(`ADCB_ADDR_PD, 8'h1e);
		`CHK("pd locked", 4'h0, pd_out)
		wr(`ADCB_ADDR_KEY, 8'h55);
		wr(`ADCB_ADDR_PD, 8'h1e);
		`CHK("pd wrong key", 4'h0, pd_out)
		wr(`ADCB_ADDR_KEY, 8'haa);
		rd(`ADCB_ADDR_KEY, 8'haa, "key");
		wr(`ADCB_ADDR_PD, 8'hff);
		`CHK("pd all", 4'hf, pd_out)
		rd(`ADCB_ADDR_PD, 8'h1e, "pd read");
		frame(adcb_pkg::adcb_cmd_clear, `ADCB_ADDR_PD, 8'h0a);
		`CHK("pd clear", 4'ha, pd_out)
		frame(adcb_pkg::adcb_cmd_set, `ADCB_ADDR_PD, 8'h02);
		`CHK("pd set", 4'hb, pd_out)
		wr(`ADCB_ADDR_OUTRSVD, 8'hff);
		rd(`ADCB_ADDR_OUTRSVD, 8'h00, "rsvd");
		rd(11'h020, 8'h00, "unmapped");
		wr(`ADCB_ADDR_OUTPROT, 8'hff);
		`CHK("outprot", 8'h77, output_protocol_ctrl)
		wr(`ADCB_ADDR_OUTRATE, 8'hff);
		`CHK("outrate", 8'h01, output_rate_ctrl)
		wr(`ADCB_ADDR_STATPIN, 8'h5a);
		`CHK("statpin", 8'h5a, status_pin_cfg)
		wr(`ADCB_ADDR_WORD, 8'ha5);
		`CHK("word", 8'ha5, output_word_cfg)
		wr(`ADCB_ADDR_PARITY, 8'h3c);
		`CHK("parity", 8'h3c, parity_cfg)
		wr(`ADCB_ADDR_SDI, 8'hff);
		`CHK("mode rsvd", 2'h3, write_protocol_field)
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, `ADCB_HOST_MODE, 32'h3);
			wr(`ADCB_ADDR_SDI, 8'(m));
			`CHK("mode", 2'(m), write_protocol_field)
			apb(1'b1, `ADCB_HOST_MODE, 32'(m));
			apb(1'b0, `ADCB_HOST_MODE, 32'h0);
			`CHK("host mode", 32'(m), r)
			rd(`ADCB_ADDR_SDI, 8'(m), "mode read");
			wr(`ADCB_ADDR_SDI, 8'h03);
		end
		// a second frame request while busy must be refused, not queued
		apb(1'b1, `ADCB_HOST_FRAME, 32'h00000000);
		`CHK("frame accepted", 1'b0, slv)
		apb(1'b1, `ADCB_HOST_FRAME, {8'h00, adcb_pkg::adcb_cmd_write, `ADCB_ADDR_PD, 8'h00});
		`CHK("frame refused", 1'b1, slv)
		frame(adcb_pkg::adcb_cmd_nop, 11'h000, 8'h00);
		`CHK("pd kept after refusal", 4'hb, pd_out)
		frame(5'h1f, `ADCB_ADDR_PD, 8'h00);
		`CHK("pd reserved command", 4'hb, pd_out)
		apb(1'b0, 12'h010, 32'h0);
		`CHK("host unmapped error", 1'b1, slv)
		`CHK("host unmapped data", 32'h00000000, r)
		wr(`ADCB_ADDR_KEY, 8'h00);
		wr(`ADCB_ADDR_PD, 8'h00);
		`CHK("pd relocked", 4'hb, pd_out)
		rd(`ADCB_ADDR_KEY, 8'h00, "key relocked");
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		`CHK("pd second reset", 4'h0, pd_out)
		rd(`ADCB_ADDR_PD, 8'h00, "pd after reset");
		give_verdict();
	end
endmodule

`default_nettype wire
